// ---- hw/xcvr_pkg.sv ----
package xcvr_pkg;
    // width of each data port
    localparam int PORT_W = 8;
    // source feeding one port's drivers
    typedef enum logic [1:0] {
        SRC_RESET  = 2'b00,
        SRC_LIVE   = 2'b01,
        SRC_STORED = 2'b10,
        SRC_TEST   = 2'b11
    } srcMode_t;
    // drive value and enable while in reset
    localparam logic [7:0] DATA_RST_VAL     = 8'h00;
    localparam logic       OE_RST_VAL       = 1'b0;
    // pin snapshots after reset
    localparam logic [7:0] SNAP_RST_VAL     = 8'h00;
    // clock history after reset; high so no false rise follows release
    localparam logic       CLK_HIST_RST_VAL = 1'b1;
endpackage : xcvr_pkg

// ---- hw/octal_registered_bus_transceiver.sv ----
// Overview of operation
// - A-port levels stored into A-to-B register on each A-to-B clock rise.
// - A-to-B select low passes live A levels to B drivers.
// - A-to-B select high presents stored A-to-B register to B drivers.
// - B port driven while its enable high, released while low.
// - B-to-A mirrors A-to-B; A-port enable is active low.
// - Register capture happens on every clock rise outside test mode, regardless of enables.
// - B driven from A and both clocks rising loads A into both.
// - A driven from B and both clocks rising loads B into both.
// - Both enables active with selects high swaps stored data both ways.
// - Test mode suspends normal path; test logic controls every pin.
// - Test port activity in normal mode leaves transceiver function untouched.
// - Pin snapshots run on the test clock, not datapath clocks; test-mode drive follows test inputs every sys_clk cycle.
`timescale 1ns/1ps
module octal_registered_bus_transceiver (
    input  wire logic       sys_clk,
    input  wire logic       srst,
    input  wire logic       aToBStoreClock,
    input  wire logic       bToAStoreClock,
    input  wire logic       aToBSourceSelect,
    input  wire logic       bToASourceSelect,
    input  wire logic       bPortDriveEnable,
    input  wire logic       aPortDriveEnable_n,
    input  wire logic [7:0] aIn,
    output logic      [7:0] aOut,
    output logic            aOe,
    input  wire logic [7:0] bIn,
    output logic      [7:0] bOut,
    output logic            bOe,
    input  wire logic       testMode,
    input  wire logic       testClk,
    input  wire logic [7:0] testAOut,
    input  wire logic       testAOe,
    input  wire logic [7:0] testBOut,
    input  wire logic       testBOe,
    output logic      [7:0] testACapture,
    output logic      [7:0] testBCapture
);
    // storage, one register per direction
    logic [xcvr_pkg::PORT_W-1:0] abStore_r;
    logic [xcvr_pkg::PORT_W-1:0] baStore_r;
    // previous samples of the slow clocks
    logic                        abClkDly_r;
    logic                        baClkDly_r;
    logic                        testClkDly_r;
    // detected rises and qualified captures
    logic                        abRise;
    logic                        baRise;
    logic                        tckRise;
    logic                        abCapture;
    logic                        baCapture;
    // levels standing on the two-way pins
    logic [xcvr_pkg::PORT_W-1:0] aPin;
    logic [xcvr_pkg::PORT_W-1:0] bPin;
    // source of each port's drivers
    xcvr_pkg::srcMode_t          aSrcMode;
    xcvr_pkg::srcMode_t          bSrcMode;
    // next values of the pin drivers
    logic [xcvr_pkg::PORT_W-1:0] aOut_nxt;
    logic [xcvr_pkg::PORT_W-1:0] bOut_nxt;
    logic                        aOe_nxt;
    logic                        bOe_nxt;

    // rise of a sampled level against its previous sample
    function automatic logic riseOf(
        input logic cur,
        input logic prev
    );
        riseOf = cur & ~prev;
    endfunction : riseOf

    // level on a two-way pin: own drive while enabled, else the far side
    function automatic logic [xcvr_pkg::PORT_W-1:0] pinLevel(
        input logic                        oe,
        input logic [xcvr_pkg::PORT_W-1:0] drv,
        input logic [xcvr_pkg::PORT_W-1:0] ext
    );
        pinLevel = oe ? drv : ext;
    endfunction : pinLevel

    // driver source from reset, test mode and source select
    function automatic xcvr_pkg::srcMode_t srcModeOf(
        input logic rst,
        input logic tm,
        input logic sel
    );
        if (rst) begin
            srcModeOf = xcvr_pkg::SRC_RESET;
        end else if (tm) begin
            srcModeOf = xcvr_pkg::SRC_TEST;
        end else if (sel) begin
            srcModeOf = xcvr_pkg::SRC_STORED;
        end else begin
            srcModeOf = xcvr_pkg::SRC_LIVE;
        end
    endfunction : srcModeOf

    // drive value of one port for its source
    function automatic logic [xcvr_pkg::PORT_W-1:0] driveValue(
        input xcvr_pkg::srcMode_t          mode,
        input logic [xcvr_pkg::PORT_W-1:0] live,
        input logic [xcvr_pkg::PORT_W-1:0] stored,
        input logic [xcvr_pkg::PORT_W-1:0] test
    );
        case (mode)
            xcvr_pkg::SRC_LIVE:   driveValue = live;
            xcvr_pkg::SRC_STORED: driveValue = stored;
            xcvr_pkg::SRC_TEST:   driveValue = test;
            default:              driveValue = xcvr_pkg::DATA_RST_VAL;
        endcase
    endfunction : driveValue

    // drive enable of one port for its source
    function automatic logic driveEnable(
        input xcvr_pkg::srcMode_t mode,
        input logic               normalOe,
        input logic               testOe
    );
        case (mode)
            xcvr_pkg::SRC_TEST:  driveEnable = testOe;
            xcvr_pkg::SRC_RESET: driveEnable = xcvr_pkg::OE_RST_VAL;
            default:             driveEnable = normalOe;
        endcase
    endfunction : driveEnable

    // history of the A-to-B store clock
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            abClkDly_r <= xcvr_pkg::CLK_HIST_RST_VAL;
        end else begin
            abClkDly_r <= aToBStoreClock;
        end
    end

    // history of the B-to-A store clock
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            baClkDly_r <= xcvr_pkg::CLK_HIST_RST_VAL;
        end else begin
            baClkDly_r <= bToAStoreClock;
        end
    end

    // history of the test clock
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            testClkDly_r <= xcvr_pkg::CLK_HIST_RST_VAL;
        end else begin
            testClkDly_r <= testClk;
        end
    end

    // rising edges of the sampled clocks
    assign abRise  = riseOf(aToBStoreClock, abClkDly_r);
    assign baRise  = riseOf(bToAStoreClock, baClkDly_r);
    assign tckRise = riseOf(testClk, testClkDly_r);

    // pin level: own drive wins, else the far side
    // B pin: B drive while bOe, else the far side bIn
    assign bPin = pinLevel(bOe, bOut, bIn);
    assign aPin = pinLevel(aOe, aOut, aIn);

    // captures; enables never gate them
    // stores frozen in test mode
    assign abCapture = abRise & ~testMode;
    assign baCapture = baRise & ~testMode;

    // store the A pin level
    // capture A pin
    always_ff @(posedge sys_clk) begin
        if (abCapture) begin
            abStore_r <= aPin;
        end
    end

    // store the B pin level
    // mirror capture, B pin
    always_ff @(posedge sys_clk) begin
        if (baCapture) begin
            baStore_r <= bPin;
        end
    end

    // driver source per port
    // test logic takes pins
    assign bSrcMode = srcModeOf(srst, testMode, aToBSourceSelect);
    assign aSrcMode = srcModeOf(srst, testMode, bToASourceSelect);

    // drive values; live path reads the pin level
    // live path
    assign bOut_nxt = driveValue(bSrcMode, aPin, abStore_r, testBOut);
    assign aOut_nxt = driveValue(aSrcMode, bPin, baStore_r, testAOut);

    // drive enables
    // B enable active high
    assign bOe_nxt = driveEnable(bSrcMode, bPortDriveEnable, testBOe);
    assign aOe_nxt = driveEnable(aSrcMode, ~aPortDriveEnable_n, testAOe);

    // A-side pin drivers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            aOut <= xcvr_pkg::DATA_RST_VAL;
            aOe  <= xcvr_pkg::OE_RST_VAL;
        end else begin
            aOut <= aOut_nxt;
            aOe  <= aOe_nxt;
        end
    end

    // B-side pin drivers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            bOut <= xcvr_pkg::DATA_RST_VAL;
            bOe  <= xcvr_pkg::OE_RST_VAL;
        end else begin
            bOut <= bOut_nxt;
            bOe  <= bOe_nxt;
        end
    end

    // observation only, datapath untouched
    // A pin snapshot
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            testACapture <= xcvr_pkg::SNAP_RST_VAL;
        end else if (tckRise) begin
            testACapture <= aPin;
        end
    end

    // B pin snapshot
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            testBCapture <= xcvr_pkg::SNAP_RST_VAL;
        end else if (tckRise) begin
            testBCapture <= bPin;
        end
    end
endmodule : octal_registered_bus_transceiver

// ---- tb/bus_partner.sv ----
`timescale 1ns/1ps
module bus_partner (
    input  wire logic       clk,
    input  wire logic       rel,
    input  wire logic [7:0] val,
    output logic      [7:0] pin
);
    // released bus shows the inverted last level
    always @(posedge clk) pin <= rel ? ~pin : val;
endmodule : bus_partner

// ---- tb/xcvr_checker.sv ----
`timescale 1ns/1ps
module xcvr_checker (
    input wire logic       sys_clk,
    input wire logic       srst,
    input wire logic       aToBStoreClock,
    input wire logic       bToAStoreClock,
    input wire logic       aToBSourceSelect,
    input wire logic       bToASourceSelect,
    input wire logic       bPortDriveEnable,
    input wire logic       aPortDriveEnable_n,
    input wire logic       testMode,
    input wire logic       aOe,
    input wire logic       bOe,
    input wire logic [7:0] aIn,
    input wire logic [7:0] bIn,
    input wire logic [7:0] aOut,
    input wire logic [7:0] bOut
);
    logic [7:0] aP, bP, sA_r, sB_r;
    logic       pA_r, pB_r, vA_r, vB_r;
    assign aP = aOe ? aOut : aIn;
    assign bP = bOe ? bOut : bIn;
    // shadow copies of both store registers
    always_ff @(posedge sys_clk) begin
        pA_r <= srst || aToBStoreClock;
        pB_r <= srst || bToAStoreClock;
        vA_r <= !srst && (vA_r || (aToBStoreClock && !pA_r && !testMode));
        vB_r <= !srst && (vB_r || (bToAStoreClock && !pB_r && !testMode));
        if (aToBStoreClock && !pA_r && !testMode) sA_r <= aP;
        if (bToAStoreClock && !pB_r && !testMode) sB_r <= bP;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    chk_b_drive: assert property ($past(!srst && !testMode) |-> bOe == $past(bPortDriveEnable))
        else $error("b drive");
    chk_a_drive: assert property ($past(!srst && !testMode) |-> aOe != $past(aPortDriveEnable_n))
        else $error("a drive");
    chk_b_live: assert property ($past(!srst && !testMode && !aToBSourceSelect) |-> bOut == $past(aP))
        else $error("b live");
    chk_a_live: assert property ($past(!srst && !testMode && !bToASourceSelect) |-> aOut == $past(bP))
        else $error("a live");
    chk_b_stored: assert property ($past(!srst && !testMode && aToBSourceSelect && vA_r) |-> bOut == $past(sA_r))
        else $error("b stored");
    chk_a_stored: assert property ($past(!srst && !testMode && bToASourceSelect && vB_r) |-> aOut == $past(sB_r))
        else $error("a stored");
    chk_both_drive: assert property ($past(!srst && !testMode && bPortDriveEnable && !aPortDriveEnable_n) |-> aOe && bOe)
        else $error("both drive");
    chk_reset_quiet: assert property (disable iff (1'b0) srst |=> !aOe && !bOe && aOut == 8'h00 && bOut == 8'h00)
        else $error("reset quiet");
    cover property (aOe && bOe && $past(aToBSourceSelect && bToASourceSelect));
    cover property (aToBStoreClock && bToAStoreClock && !pA_r && !pB_r);
    cover property (testMode && bOe);
endmodule : xcvr_checker
bind octal_registered_bus_transceiver xcvr_checker xcvr_checker_i (.*);

// ---- tb/tb_octal_registered_bus_transceiver.sv ----
`timescale 1ns/1ps
`define CHK(a, e) begin nTests++; if ((a) !== (e)) begin errCount++; $display("wrong value t=%0t got %h exp %h", $time, a, e); end end
module tb_octal_registered_bus_transceiver;
    logic sys_clk = 1'b0, srst = 1'b1, aToBStoreClock = 1'b0, bToAStoreClock = 1'b0;
    logic aToBSourceSelect = 1'b0, bToASourceSelect = 1'b0, bPortDriveEnable = 1'b0;
    logic aPortDriveEnable_n = 1'b1, testMode = 1'b0, testClk = 1'b0, testAOe = 1'b0;
    logic testBOe = 1'b0, aOe, bOe, eAoe, eBoe, pA, pB, pT, ca, cb;
    logic [7:0] aIn, bIn, aOut, bOut, testACapture, testBCapture;
    logic [7:0] testAOut = 8'h00, testBOut = 8'h00;
    logic [7:0] aV = 8'h00, bV = 8'h00, eAo, eBo, eCa, eCb, sa, sb, ap, bp, r;
    int errCount = 0, nTests = 0, seed = 32'hD5B2, k;
    octal_registered_bus_transceiver octal_registered_bus_transceiver_i (.*);
    bus_partner bus_partner_i (.clk(sys_clk), .rel(aOe), .val(aV), .pin(aIn));
    bus_partner bus_partner_b_i (.clk(sys_clk), .rel(bOe), .val(bV), .pin(bIn));
    initial forever #4 sys_clk = ~sys_clk;
    // expected drive value of one port
    function automatic logic [7:0] pick(input logic rst, tm, sel,
                                        input logic [7:0] tOut, st, live);
        pick = rst ? 8'h00 : tm ? tOut : sel ? st : live;
    endfunction : pick
    // reference model of pins, stores and snapshots
    always @(posedge sys_clk) begin
        ap = eAoe ? eAo : aIn;
        bp = eBoe ? eBo : bIn;
        eBo = pick(srst, testMode, aToBSourceSelect, testBOut, sa, ap);
        eAo = pick(srst, testMode, bToASourceSelect, testAOut, sb, bp);
        eBoe = !srst && (testMode ? testBOe : bPortDriveEnable);
        eAoe = !srst && (testMode ? testAOe : !aPortDriveEnable_n);
        if (aToBStoreClock && !pA && !testMode) sa = ap;
        if (bToAStoreClock && !pB && !testMode) sb = bp;
        if (srst) {eCa, eCb} = 16'h0000;
        else if (testClk && !pT) {eCa, eCb} = {ap, bp};
        {pA, pB, pT} = srst ? 3'h7 : {aToBStoreClock, bToAStoreClock, testClk};
    end
    always @(negedge sys_clk) begin
        `CHK({aOut, aOe, bOut, bOe}, {eAo, eAoe, eBo, eBoe})
        `CHK({testACapture, testBCapture}, {eCa, eCb})
    end
    task reportAndStop;
        $display("checks %0d mismatches %0d", nTests, errCount);
        if (errCount == 0 && nTests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : reportAndStop
    initial begin
        #(4000 * 8);
        errCount++;
        reportAndStop;
    end
    initial begin
        repeat (3) @(posedge sys_clk);
        srst <= 0;
        for (k = 0; k < 3000; k++) begin
            @(posedge sys_clk);
            r = 8'($random(seed));
            aV <= 8'($random(seed));
            bV <= 8'($random(seed));
            testAOut <= 8'($random(seed));
            testBOut <= 8'($random(seed));
            // mid-run reset; stores keep their contents
            srst <= k >= 1500 && k < 1503;
            {testAOe, testBOe, testClk} <= r[7:5];
            // load both stores in isolation, then swap stored data both ways
            {aToBSourceSelect, bToASourceSelect} <= k < 100 ? 2'h3 : r[4:3];
            {bPortDriveEnable, aPortDriveEnable_n} <= k < 20 ? 2'h1 : k < 100 ? 2'h2 : r[2:1];
            testMode <= k > 100 && ($random(seed) & 15) == 0;
            ca = k < 20 ? k[0] : r[0];
            cb = k < 20 ? !k[0] : r[6];
            aToBStoreClock <= ca;
            bToAStoreClock <= cb && !(ca && !aToBStoreClock && (k < 100 || r[4] || r[3]));
        end
        $display("test random done");
        reportAndStop;
    end
endmodule : tb_octal_registered_bus_transceiver
